// File: hdl/twi_pkg.sv
// Shared constants for the two-wire master and general-call port
package twi_pkg;
	localparam int unsigned CLK_HZ = 100_000_000;
	localparam logic [3:0] MODE_MASTER = 4'h8;
	localparam logic [3:0] MODE_SLAVE7 = 4'h6;
	localparam logic [3:0] MODE_SLAVE10 = 4'h7;
	localparam logic [3:0] MODE_SLAVE7_SP = 4'he;
	localparam logic [3:0] MODE_SLAVE10_SP = 4'hf;
	localparam logic [7:0] GENERAL_CALL_ADDR = 8'h00;
	localparam logic [7:0] TEN_BIT_PREFIX = 8'hf0;
	localparam logic [7:0] TEN_BIT_MASK = 8'hf9;
	localparam int unsigned RELOAD_W = 7;
	localparam int unsigned CON2_LOCK_BITS = 5;
	localparam logic [RELOAD_W-1:0] BAUD_RESET = 7'h00;
	localparam logic [1:0] PHASE_RESET = 2'h0;
	localparam logic [3:0] BIT_COUNT_BYTE = 4'h8;
	localparam logic [3:0] BIT_COUNT_ACK = 4'h9;
endpackage : twi_pkg

// File: hdl/baud_gen.sv
// Reloadable down counter that steps on two phases of a four-phase cycle
`timescale 1ns/1ns
module baud_gen #(
	parameter int unsigned W = twi_pkg::RELOAD_W
) (
	input wire logic clock,
	input wire logic rst_b,
	input wire logic load,
	input wire logic halt,
	input wire logic [W-1:0] reload,
	output logic timeout,
	output logic running
);
	logic [W-1:0] baud_counter;
	logic [1:0] phase;

	// Four-phase instruction cycle; steps on phase_two and phase_four only
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			phase <= twi_pkg::PHASE_RESET;
		end else begin
			phase <= phase + 2'h1;
		end
	end

	// Count down to zero then park until reloaded
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			baud_counter <= twi_pkg::BAUD_RESET;
			running <= 1'b0;
		end else if (load) begin
			baud_counter <= reload;
			running <= 1'b1;
		end else if (halt) begin
			running <= 1'b0;
		end else if (running && phase[0]) begin
			if (baud_counter == '0) begin
				running <= 1'b0;
			end else begin
				baud_counter <= baud_counter - {{(W-1){1'b0}}, 1'b1};
			end
		end
	end

	// One-cycle pulse when the count expires; period (reload+1) half-cycles
	assign timeout = running && phase[0] && (baud_counter == '0);
endmodule : baud_gen

// File: hdl/twi_port.sv
// Two-wire port: master Start, byte transmit with acknowledge, general call
`timescale 1ns/1ns
module twi_port (
	input wire logic clock,
	input wire logic rst_b,
	input wire logic port_enable_bit,
	input wire logic [3:0] port_mode_select,
	input wire logic general_call_enable,
	input wire logic [7:0] address_baud_reg,
	input wire logic con2_wr,
	input wire logic [4:0] con2_wdata,
	input wire logic buf_wr,
	input wire logic [7:0] buf_wdata,
	input wire logic buf_rd,
	input wire logic irq_clr,
	input wire logic wr_collision_clr,
	input wire logic bcol_clr,
	input wire logic scl_in,
	input wire logic sda_in,
	output logic scl_out,
	output logic scl_oe,
	output logic sda_out,
	output logic sda_oe,
	output logic [4:0] second_control_reg,
	output logic [7:0] serial_xfer_buffer,
	output logic buffer_full_flag,
	output logic serial_irq_flag,
	output logic write_collision_flag,
	output logic bus_collision_flag,
	output logic ack_status_flag,
	output logic update_addr_flag,
	output logic start_seen,
	output logic stop_seen
);
	typedef enum logic [3:0] {
		M_IDLE, M_START_WAIT, M_START_HOLD, M_BIT_LOW, M_BIT_HIGH, M_ACK_LOW, M_ACK_HIGH,
		M_HOLD
	} mstate_e;

	mstate_e mstate;
	logic [7:0] serial_shift_reg;
	logic [3:0] mbits;
	logic sda_drv_low;
	logic scl_drv_low;
	logic master_mode;
	logic start_cond_enable;
	logic baud_load;
	logic baud_halt;
	logic baud_timeout;
	logic baud_running;
	logic ev_start;
	logic ev_byte;
	logic ev_bcol;
	logic scl_q;
	logic sda_q;
	logic s_start;
	logic s_stop;
	logic s_rise;
	logic s_fall;
	logic [7:0] s_shift;
	logic [3:0] s_bits;
	logic s_active;
	logic gc_hit;
	logic ev_gc_buf;
	logic ev_gc_irq;
	logic gc_pending;

	// Decodes whether a byte is the reserved broadcast address
	function automatic logic is_general_call(input logic [7:0] b);
		return b == twi_pkg::GENERAL_CALL_ADDR;
	endfunction : is_general_call

	function automatic logic is_ten_bit_mode(input logic [3:0] m);
		return m == twi_pkg::MODE_SLAVE10 || m == twi_pkg::MODE_SLAVE10_SP;
	endfunction : is_ten_bit_mode

	assign master_mode = port_enable_bit && port_mode_select == twi_pkg::MODE_MASTER;
	assign start_cond_enable = second_control_reg[0];

	// Open-drain pins: only ever pull low, otherwise release
	assign scl_out = 1'b0;
	assign sda_out = 1'b0;
	assign scl_oe = scl_drv_low;
	assign sda_oe = sda_drv_low;

	// Previous line levels for bus edge detection
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			scl_q <= 1'b1;
			sda_q <= 1'b1;
		end else begin
			scl_q <= scl_in;
			sda_q <= sda_in;
		end
	end

	assign s_start = scl_in && scl_q && sda_q && !sda_in;
	assign s_stop = scl_in && scl_q && !sda_q && sda_in;
	assign s_rise = scl_in && !scl_q;
	assign s_fall = !scl_in && scl_q;

	baud_gen #(
		.W(twi_pkg::RELOAD_W)
	) baud_gen_inst (
		.clock(clock),
		.rst_b(rst_b),
		.load(baud_load),
		.halt(baud_halt),
		.reload(address_baud_reg[twi_pkg::RELOAD_W-1:0]),
		.timeout(baud_timeout),
		.running(baud_running)
	);

	// Counter load: Start with idle lines, buffer write, end of each low or data-high phase, or clock held low
	always_comb begin
		baud_load = 1'b0;
		baud_halt = 1'b0;
		case (mstate)
			M_IDLE: baud_load = master_mode && start_cond_enable && scl_in && sda_in;
			M_START_WAIT: baud_load = baud_timeout && scl_in && sda_in;
			M_START_HOLD: baud_halt = baud_timeout;
			M_HOLD: baud_load = buf_wr && !buffer_full_flag;
			M_BIT_LOW, M_ACK_LOW: baud_load = baud_timeout;
			M_BIT_HIGH, M_ACK_HIGH: baud_load = !scl_q || (mstate == M_BIT_HIGH && baud_timeout);
			default: baud_load = 1'b0;
		endcase
	end

	// Master sequencer: Start, then eight bits plus acknowledge per byte
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			mstate <= M_IDLE;
			scl_drv_low <= 1'b0;
			sda_drv_low <= 1'b0;
			mbits <= 4'h0;
			serial_shift_reg <= 8'h00;
			ack_status_flag <= 1'b0;
		end else if (!master_mode) begin
			mstate <= M_IDLE;
			scl_drv_low <= 1'b0;
			sda_drv_low <= 1'b0;
		end else begin
			case (mstate)
				M_IDLE: begin
					if (start_cond_enable) begin
						mstate <= (scl_in && sda_in) ? M_START_WAIT : M_IDLE;
					end
				end
				M_START_WAIT: begin
					if (!scl_in || !sda_in) begin
						mstate <= M_IDLE;
					end else if (baud_timeout) begin
						sda_drv_low <= 1'b1;
						mstate <= M_START_HOLD;
					end
				end
				M_START_HOLD: begin
					if (baud_timeout) begin
						mstate <= M_HOLD;
					end
				end
				M_HOLD: begin
					// Clock released after a Start, parked low after each byte's ack; waits for a byte
					if (buf_wr && !buffer_full_flag) begin
						serial_shift_reg <= buf_wdata;
						scl_drv_low <= 1'b1;
						mbits <= 4'h0;
						mstate <= M_BIT_LOW;
					end
				end
				M_BIT_LOW: begin
					sda_drv_low <= !serial_shift_reg[7];
					if (baud_timeout) begin
						scl_drv_low <= 1'b0;
						mstate <= M_BIT_HIGH;
					end
				end
				M_BIT_HIGH: begin
					if (baud_timeout) begin
						scl_drv_low <= 1'b1;
						serial_shift_reg <= {serial_shift_reg[6:0], 1'b0};
						mbits <= mbits + 4'h1;
						mstate <= (mbits + 4'h1 == twi_pkg::BIT_COUNT_BYTE) ? M_ACK_LOW : M_BIT_LOW;
					end
				end
				M_ACK_LOW: begin
					sda_drv_low <= 1'b0; // Release data for the slave
					if (baud_timeout) begin
						scl_drv_low <= 1'b0;
						mstate <= M_ACK_HIGH;
					end
				end
				M_ACK_HIGH: begin
					if (baud_timeout) begin
						ack_status_flag <= sda_in;
						scl_drv_low <= 1'b1;
						mstate <= M_HOLD;
					end
				end
				default: mstate <= M_IDLE;
			endcase
		end
	end

	assign ev_start = mstate == M_START_HOLD && baud_timeout;
	assign ev_byte = mstate == M_ACK_HIGH && baud_timeout;
	assign ev_bcol = master_mode && ((mstate == M_IDLE && start_cond_enable && !(scl_in && sda_in))
		|| (mstate == M_START_WAIT && (!scl_in || !sda_in)));

	// Control bits; locked while a Start is running, start enable self-clears
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			second_control_reg <= 5'h00;
		end else if (ev_start || ev_bcol) begin
			second_control_reg[0] <= 1'b0;
		end else if (con2_wr && !start_cond_enable && mstate != M_START_HOLD) begin
			second_control_reg <= con2_wdata[twi_pkg::CON2_LOCK_BITS-1:0];
		end
	end

	// Bus state seen on the lines; cleared on reset and while disabled
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			start_seen <= 1'b0;
			stop_seen <= 1'b0;
		end else if (!port_enable_bit) begin
			start_seen <= 1'b0;
			stop_seen <= 1'b0;
		end else if (s_start) begin
			start_seen <= 1'b1;
			stop_seen <= 1'b0;
		end else if (s_stop) begin
			stop_seen <= 1'b1;
			start_seen <= 1'b0;
		end
	end

	// Slave receiver: shifts on rising clock, compares at eighth bit
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			s_shift <= 8'h00;
			s_bits <= 4'h0;
			s_active <= 1'b0;
			gc_pending <= 1'b0;
		end else if (!port_enable_bit || master_mode || s_start || s_stop) begin
			s_bits <= 4'h0;
			s_active <= s_start && port_enable_bit && !master_mode;
			gc_pending <= 1'b0;
		end else if (s_active) begin
			if (s_rise && s_bits < twi_pkg::BIT_COUNT_BYTE) begin
				s_shift <= {s_shift[6:0], sda_in};
				s_bits <= s_bits + 4'h1;
			end else if (s_fall && s_bits == twi_pkg::BIT_COUNT_BYTE) begin
				gc_pending <= gc_hit;
				s_bits <= twi_pkg::BIT_COUNT_ACK;
			end else if (s_fall && s_bits == twi_pkg::BIT_COUNT_ACK) begin
				gc_pending <= 1'b0;
				s_active <= 1'b0; // Data phase of a broadcast is left to software
			end
		end
	end

	// Broadcast match needs the enable; there is no own-address match
	assign gc_hit = general_call_enable && is_general_call(s_shift);
	assign ev_gc_buf = s_active && s_fall && s_bits == twi_pkg::BIT_COUNT_BYTE && gc_hit
		&& !buffer_full_flag;
	assign ev_gc_irq = s_active && s_fall && s_bits == twi_pkg::BIT_COUNT_ACK && gc_pending;

	// Ten-bit mode: broadcast never raises the update-address flag
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			update_addr_flag <= 1'b0;
		end else if (s_active && s_fall && s_bits == twi_pkg::BIT_COUNT_BYTE
			&& is_ten_bit_mode(port_mode_select) && !gc_hit
			&& (s_shift & twi_pkg::TEN_BIT_MASK) == twi_pkg::TEN_BIT_PREFIX) begin
			update_addr_flag <= 1'b1;
		end else if (!port_enable_bit || ev_gc_buf) begin
			update_addr_flag <= 1'b0;
		end
	end

	// Transfer buffer and full flag; writes rejected while busy set collision
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			serial_xfer_buffer <= 8'h00;
			buffer_full_flag <= 1'b0;
		end else if (ev_gc_buf) begin
			serial_xfer_buffer <= s_shift;
			buffer_full_flag <= 1'b1;
		end else if (buf_wr && master_mode && mstate == M_HOLD && !buffer_full_flag) begin
			serial_xfer_buffer <= buf_wdata;
			buffer_full_flag <= 1'b1;
		end else if (mstate == M_BIT_HIGH && baud_timeout && mbits == 4'h7) begin
			buffer_full_flag <= 1'b0; // Cleared once all eight bits leave
		end else if (buf_rd) begin
			buffer_full_flag <= 1'b0;
		end
	end

	// Write collision is sticky; set wins over software clear
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			write_collision_flag <= 1'b0;
		end else if (buf_wr && master_mode && mstate != M_HOLD) begin
			write_collision_flag <= 1'b1;
		end else if (wr_collision_clr) begin
			write_collision_flag <= 1'b0;
		end
	end

	// Bus collision flag, sticky until software clears it
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			bus_collision_flag <= 1'b0;
		end else if (ev_bcol) begin
			bus_collision_flag <= 1'b1;
		end else if (bcol_clr) begin
			bus_collision_flag <= 1'b0;
		end
	end

	// Port event flag: Start, byte done, broadcast received; set beats clear
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			serial_irq_flag <= 1'b0;
		end else if (ev_start || ev_byte || ev_gc_irq) begin
			serial_irq_flag <= 1'b1;
		end else if (irq_clr) begin
			serial_irq_flag <= 1'b0;
		end
	end
endmodule : twi_port

// File: sim/twi_port_props.sv
// Checker for the two-wire port
`timescale 1ns/1ns
module twi_port_props (
	input wire logic clock,
	input wire logic rst_b,
	input wire logic port_enable_bit,
	input wire logic con2_wr,
	input wire logic buf_wr,
	input wire logic buf_rd,
	input wire logic wr_collision_clr,
	input wire logic scl_out,
	input wire logic scl_oe,
	input wire logic sda_out,
	input wire logic sda_oe,
	input wire logic [4:0] second_control_reg,
	input wire logic [7:0] serial_xfer_buffer,
	input wire logic buffer_full_flag,
	input wire logic serial_irq_flag,
	input wire logic write_collision_flag,
	input wire logic bus_collision_flag,
	input wire logic update_addr_flag,
	input wire logic start_seen,
	input wire logic stop_seen
);
	default clocking cb @(posedge clock); endclocking
	default disable iff (!rst_b);
	// Open-drain pins only ever pull low
	pin_low_a: assert property (!scl_out && !sda_out) else $error("line driven high");
	start_flag_a: assert property ($rose(sda_oe) && second_control_reg[0] |->
		##[0:3] start_seen) else $error("start not flagged");
	start_done_a: assert property ($fell(second_control_reg[0]) && !bus_collision_flag
		|-> ##[0:2] (serial_irq_flag && sda_oe)) else $error("start end wrong");
	off_clear_a: assert property (!port_enable_bit |=> !start_seen && !stop_seen)
		else $error("status kept while off");
	write_drop_a: assert property (buf_wr && second_control_reg[0] |=>
		write_collision_flag && $stable(serial_xfer_buffer)) else $error("write queued");
	con2_lock_a: assert property (con2_wr && second_control_reg[0] |=>
		$stable(second_control_reg[4:1])) else $error("control written in start");
	collision_sticky_a: assert property (write_collision_flag && !wr_collision_clr |=>
		write_collision_flag)
		else $error("collision flag lost");
	bcol_abort_a: assert property ($rose(bus_collision_flag) |->
		!second_control_reg[0] && !sda_oe) else $error("start not aborted");
	gc_no_update_a: assert property ($rose(buffer_full_flag) && serial_xfer_buffer == 8'h00
		|=> !update_addr_flag) else $error("update flag on broadcast");
	sda_free_a: assert property ($fell(buffer_full_flag) && !$past(buf_rd) |->
		##[0:2] !sda_oe) else $error("data not released");
	cover property ($fell(second_control_reg[0]) && sda_oe);
	cover property ($rose(bus_collision_flag));
	cover property ($rose(serial_irq_flag) && !scl_oe);
endmodule : twi_port_props

bind twi_port twi_port_props twi_port_props_inst (.clock(clock), .rst_b(rst_b),
	.port_enable_bit(port_enable_bit), .con2_wr(con2_wr), .buf_wr(buf_wr), .buf_rd(buf_rd),
	.wr_collision_clr(wr_collision_clr), .scl_out(scl_out), .scl_oe(scl_oe), .sda_out(sda_out),
	.sda_oe(sda_oe), .second_control_reg(second_control_reg),
	.serial_xfer_buffer(serial_xfer_buffer), .buffer_full_flag(buffer_full_flag),
	.serial_irq_flag(serial_irq_flag), .write_collision_flag(write_collision_flag),
	.bus_collision_flag(bus_collision_flag), .update_addr_flag(update_addr_flag),
	.start_seen(start_seen), .stop_seen(stop_seen));

// File: sim/twi_slave_model.sv
// Far-side slave: shifts in each byte, answers the ninth bit, may stretch
`timescale 1ns/1ns
module twi_slave_model (
	input wire logic scl,
	input wire logic sda,
	input wire logic ack_en,
	input wire logic stretch,
	output logic sda_pull,
	output logic scl_hold,
	output logic [7:0] rx_byte
);
	int cnt = 0;
	initial begin
		sda_pull = 1'b0;
		scl_hold = 1'b0;
		rx_byte = 8'h00;
	end
	// Data falling while the clock is high opens a frame
	always @(negedge sda) if (scl) cnt = 0;
	// Bits are taken on the rising clock, top bit first
	always @(posedge scl) begin
		if (cnt < 8) rx_byte = {rx_byte[6:0], sda};
		// Ninth pulse closes the byte so the next one is taken without a new Start
		cnt = (cnt == 8) ? 0 : cnt + 1;
	end
	// Ack pulled after the eighth bit, let go after the ninth
	always @(negedge scl) sda_pull <= ack_en && cnt == 8;
	// Slow answer: clock held low a while, so the master must wait for it
	always @(negedge scl) if (stretch) begin
		scl_hold = 1'b1;
		#254 scl_hold = 1'b0; // Let go off the clock edge
	end
endmodule : twi_slave_model

// File: sim/twi_port_test.sv
// Self-checking bench for the two-wire port
`timescale 1ns/1ns
module twi_port_test;
	logic clock = 1'b0;
	logic rst_b = 1'b0;
	logic port_enable_bit = 1'b0;
	logic [3:0] port_mode_select = twi_pkg::MODE_MASTER;
	logic general_call_enable = 1'b0;
	logic [7:0] address_baud_reg = 8'h84;
	logic con2_wr = 1'b0, buf_wr = 1'b0, buf_rd = 1'b0;
	logic irq_clr = 1'b0, wr_collision_clr = 1'b0, bcol_clr = 1'b0;
	logic [4:0] con2_wdata = 5'h00;
	logic [7:0] buf_wdata = 8'h00;
	logic tb_scl_low = 1'b0, tb_sda_low = 1'b0, ack_en = 1'b0, stretch = 1'b0;
	logic scl_out, scl_oe, sda_out, sda_oe, buffer_full_flag, serial_irq_flag;
	logic write_collision_flag, bus_collision_flag, ack_status_flag, update_addr_flag;
	logic start_seen, stop_seen, sda_pull, scl_hold;
	logic [4:0] second_control_reg;
	logic [7:0] serial_xfer_buffer, rx_byte;
	int error_cnt = 0, n_compared = 0;
	// Pull-ups: a line is low while any party pulls it
	wire logic scl_in = !(scl_oe || tb_scl_low || scl_hold);
	wire logic sda_in = !(sda_oe || tb_sda_low || sda_pull);
	always #5 clock = !clock;
	twi_port twi_port_inst (.clock(clock), .rst_b(rst_b), .port_enable_bit(port_enable_bit),
		.port_mode_select(port_mode_select), .general_call_enable(general_call_enable),
		.address_baud_reg(address_baud_reg), .con2_wr(con2_wr), .con2_wdata(con2_wdata),
		.buf_wr(buf_wr), .buf_wdata(buf_wdata), .buf_rd(buf_rd), .irq_clr(irq_clr),
		.wr_collision_clr(wr_collision_clr), .bcol_clr(bcol_clr), .scl_in(scl_in), .sda_in(sda_in),
		.scl_out(scl_out), .scl_oe(scl_oe), .sda_out(sda_out), .sda_oe(sda_oe),
		.second_control_reg(second_control_reg), .serial_xfer_buffer(serial_xfer_buffer),
		.buffer_full_flag(buffer_full_flag), .serial_irq_flag(serial_irq_flag),
		.write_collision_flag(write_collision_flag), .bus_collision_flag(bus_collision_flag),
		.ack_status_flag(ack_status_flag), .update_addr_flag(update_addr_flag),
		.start_seen(start_seen), .stop_seen(stop_seen));
	twi_slave_model twi_slave_model_inst (.scl(scl_in), .sda(sda_in), .ack_en(ack_en),
		.stretch(stretch), .sda_pull(sda_pull), .scl_hold(scl_hold), .rx_byte(rx_byte));
	task automatic tick(input int n);
		repeat (n) @(posedge clock);
		#1;
	endtask : tick
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		n_compared++;
		if (seen !== exp) begin
			error_cnt++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check
	// Every clear strobe at once; flags set by the design outlive this
	task automatic clr_all();
		{irq_clr, wr_collision_clr, bcol_clr, buf_rd} = 4'hf;
		tick(1);
		{irq_clr, wr_collision_clr, bcol_clr, buf_rd} = 4'h0;
	endtask : clr_all
	task automatic wait_irq();
		int k = 0;
		while (serial_irq_flag !== 1'b1 && k < 3000) begin
			tick(1);
			k++;
		end
	endtask : wait_irq
	task automatic pulse_start();
		con2_wdata = 5'h01;
		con2_wr = 1'b1;
		tick(1);
		con2_wr = 1'b0;
	endtask : pulse_start
	// Start with a byte and a control write pushed in too early
	task automatic t_start();
		con2_wdata = 5'h01;
		con2_wr = 1'b1;
		tick(1);
		buf_wdata = 8'h5a;
		con2_wdata = 5'h1e;
		buf_wr = 1'b1; // Control write strobe stays up into the locked window
		tick(1);
		{buf_wr, con2_wr} = 2'h0;
		tick(1);
		check(write_collision_flag, 1'b1);
		check(serial_xfer_buffer, 8'h00);
		wait_irq();
		check(serial_irq_flag, 1'b1);
		check({start_seen, sda_oe, scl_oe}, 8'h06);
		check(second_control_reg, 8'h00);
		clr_all();
	endtask : t_start
	// One byte out; high time of the clock measured against the reload
	task automatic t_byte(input logic [7:0] data, input logic ack);
		int n = 0;
		int lo = ((address_baud_reg & 8'h7f) + 1) * 2;
		ack_en = ack;
		buf_wdata = data;
		buf_wr = 1'b1;
		tick(1);
		buf_wr = 1'b0;
		check(buffer_full_flag, 1'b1);
		while (scl_in !== 1'b1) tick(1);
		while (scl_in === 1'b1) begin
			tick(1);
			n++;
		end
		check(n >= lo && n <= lo + 2, 1'b1);
		wait_irq();
		check({serial_irq_flag, buffer_full_flag}, 8'h02);
		check(rx_byte, data);
		check(ack_status_flag, !ack);
		tick(40);
		check(scl_oe, 1'b1);
		clr_all();
	endtask : t_byte
	// Data held low by another party when the start is asked for
	task automatic t_collide();
		tb_sda_low = 1'b1;
		pulse_start();
		tick(30);
		check({bus_collision_flag, second_control_reg[0], sda_oe}, 8'h04);
		tb_sda_low = 1'b0;
		clr_all();
	endtask : t_collide
	// Address byte sent by a bench master: eight bits of addr, then ack slot
	task automatic t_gc(input logic [7:0] addr, input logic [3:0] mode, input logic gce,
		input logic exp, input logic exp_ua);
		port_mode_select = mode;
		general_call_enable = gce;
		tick(4);
		tb_sda_low = 1'b1;
		tick(20);
		for (int i = 0; i < 9; i++) begin
			tb_scl_low = 1'b1;
			tick(10);
			tb_sda_low = (i < 8) ? !addr[7 - i] : 1'b0;
			tick(10);
			tb_scl_low = 1'b0;
			tick(20);
		end
		tb_scl_low = 1'b1;
		tick(20);
		check({buffer_full_flag, serial_irq_flag}, {6'h00, exp, exp});
		if (exp) check(serial_xfer_buffer, 8'h00);
		check(update_addr_flag, exp_ua);
		tb_sda_low = 1'b1;
		tick(10);
		tb_scl_low = 1'b0;
		tick(10);
		tb_sda_low = 1'b0;
		clr_all();
	endtask : t_gc
	task automatic final_report();
		$display("checks %0d, mismatches %0d", n_compared, error_cnt);
		if (error_cnt == 0 && n_compared > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask : final_report
	// Main sequence; the first start is asked for with data held low, the second on an idle bus
	initial begin
		tick(12);
		rst_b = 1'b1;
		tick(1);
		check({buffer_full_flag, serial_irq_flag, write_collision_flag, bus_collision_flag,
			start_seen, stop_seen, sda_oe, scl_oe}, 8'h00);
		port_enable_bit = 1'b1;
		tick(2);
		t_collide();
		t_start();
		t_byte(8'ha5, 1'b1);
		stretch = 1'b1;
		t_byte(8'h3c, 1'b0);
		stretch = 1'b0;
		port_enable_bit = 1'b0;
		tick(2);
		check({start_seen, stop_seen}, 8'h00);
		rst_b = 1'b0;
		tick(2);
		rst_b = 1'b1;
		port_enable_bit = 1'b1;
		// Ten-bit prefix raises the update flag; the broadcast after it must clear it
		t_gc(8'hf0, twi_pkg::MODE_SLAVE10, 1'b1, 1'b0, 1'b1);
		t_gc(8'h00, twi_pkg::MODE_SLAVE10, 1'b1, 1'b1, 1'b0);
		t_gc(8'h00, twi_pkg::MODE_SLAVE7, 1'b1, 1'b1, 1'b0);
		t_gc(8'h00, twi_pkg::MODE_SLAVE10, 1'b0, 1'b0, 1'b0);
		final_report();
	end
	// Watchdog sized well past the longest expected run
	initial begin
		tick(30000);
		error_cnt++;
		final_report();
	end
endmodule : twi_port_test
